// ### rtl/regulator_fault_supervisor.sv
// fault latches, power-good, overvoltage and daisy-chain checking
// assumes comparator flags, code pins and chain input are synchronous levels;
// aresetn stands for a bias-rail power cycle
//
// Overview of operation
// - rail above 94% clears, below 86% sets
// - illegal voltage codes set main fault latch
// - illegal code must persist 1.3us first
// - eight-bit boot mode code fault stays latched
// - power-good only after ramp above 3.92V
// - any fault latch drops power-good
// - power-good holds while output within 300mV
// - amplifier high 8 switching cycles sets fault
// - enable thresholds follow the code family
// - thermal alarm pulls low on trip
// - overvoltage raises output, latch, share pullup
// - overvoltage latch clears only by power cycle
// - power-up overvoltage uses fixed 1.73V threshold
// - pre-charged output: check after ramp 3.92V
// - dynamic change over 50mV uses fixed threshold
// - sense amp below 200mV injects test pulses
// - open sense line sets sticky latch
// - power-up chain pulse, 32 clocks, one retry
// - running chain pulse within phase count
// - measure return time as phase count
// - one phase switches at clock rate
// - fault latch clears after ramp discharge
//
// Chosen here: the AXI4-Lite register port and the address map.
module regulator_fault_supervisor
    import supervisor_pkg::*;
(
    // clock and reset
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    // register bus write
    input  wire logic [3:0]                    awaddr,
    input  wire logic                          awvalid,
    output      logic                          awready,
    input  wire logic [31:0]                   wdata,
    input  wire logic [3:0]                    wstrb,
    input  wire logic                          wvalid,
    output      logic                          wready,
    output      logic [1:0]                    bresp,
    output      logic                          bvalid,
    input  wire logic                          bready,
    // register bus read
    input  wire logic [3:0]                    araddr,
    input  wire logic                          arvalid,
    output      logic                          arready,
    output      logic [31:0]                   rdata,
    output      logic [1:0]                    rresp,
    output      logic                          rvalid,
    input  wire logic                          rready,
    // analog comparators and code pins
    input  wire supervisor_pkg::comp_flags_t   comp_flags,
    input  wire logic [7:0]                    voltage_code,
    // daisy chain
    input  wire logic                          chain_phase_input,
    output      logic                          chain_phase_output,
    output      logic                          phase_timing_clock_out,
    // supervisor pins
    output      supervisor_pkg::supervisor_out_t pins
);
    import supervisor_pkg::*;

    function automatic logic code_illegal(input logic [7:0] code, input logic five);
        if (five) begin
            return code[4:0] == 5'h1F;
        end
        return (code[7:1] == 7'h00) || (code[7:1] == 7'h7F);
    endfunction : code_illegal

    comp_flags_t  flags_meta;
    comp_flags_t  flags;
    logic         chain_meta;
    logic         chain_sync;
    logic         chain_prev;
    logic [1:0]   ctrl;
    logic [3:0]   div_cnt;
    logic         tick;
    logic [7:0]   qual_cnt;
    logic         code_bad;
    logic         code_fault_now;
    logic         code_sticky;
    logic [3:0]   loop_cnt;
    logic         loop_latch;
    logic         en_low;
    logic         en_high;
    logic         fault_set;
    logic         fault_latch;
    logic         ramp_seen;
    logic         use_fixed;
    logic         ov_trip;
    logic         ov_latch;
    logic         sense_latch;
    logic         chain_latch;
    logic         any_latch;
    chain_state_t chain_state;
    logic [5:0]   chain_cnt;
    logic [5:0]   phase_count;
    logic         learned;
    logic         missed_once;
    logic         chain_back;
    logic         launch;
    logic [5:0]   chain_limit;
    logic [3:0]   aw_addr;
    logic [7:0]   w_byte0;
    logic         w_strb0;
    logic         aw_full;
    logic         w_full;
    logic         do_write;
    logic [31:0]  read_word;
    logic         read_ok;

    // two-stage synchronisers, first stage read only by the second
    always_ff @(posedge aclk) begin
        flags_meta <= comp_flags;
        flags      <= flags_meta;
        chain_meta <= chain_phase_input;
        chain_sync <= chain_meta;
        chain_prev <= chain_sync;
    end

    // phase timing clock enable
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_cnt <= 4'h0;
            phase_timing_clock_out <= 1'b0;
        end else begin
            div_cnt <= div_cnt + 4'h1;
            phase_timing_clock_out <= tick;
        end
    end
    assign tick = div_cnt == PHASE_DIV_LAST;

    // illegal code qualification
    assign code_bad = code_illegal(voltage_code, ctrl[CTRL_FIVE_BIT]);
    assign code_fault_now = qual_cnt == CODE_QUAL_CNT;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            qual_cnt <= 8'h00;
            code_sticky <= 1'b0;
        end else begin
            if (!code_bad) begin
                qual_cnt <= 8'h00;
            end else if (!code_fault_now) begin
                qual_cnt <= qual_cnt + 8'h01;
            end
            if (code_fault_now && !ctrl[CTRL_FIVE_BIT] && ctrl[CTRL_BOOT_BIT]) begin
                code_sticky <= 1'b1;
            end
        end
    end

    // open loop: amplifier high across consecutive switching cycles
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            loop_cnt <= 4'h0;
            loop_latch <= 1'b0;
        end else begin
            if (!flags.ea_high) begin
                loop_cnt <= 4'h0;
            end else if (launch && !loop_latch) begin
                if (loop_cnt == OPEN_LOOP_LAST) begin
                    loop_latch <= 1'b1;
                end
                loop_cnt <= loop_cnt + 4'h1;
            end
        end
    end

    // main fault latch
    assign en_low  = ctrl[CTRL_FIVE_BIT] ? flags.en_low_5 : flags.en_low_8;
    assign en_high = ctrl[CTRL_FIVE_BIT] ? flags.en_high_5 : flags.en_high_8;
    assign fault_set = flags.bias_below_86 | code_fault_now | code_sticky
                     | loop_latch | en_low;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fault_latch <= 1'b1;
        end else if (fault_set) begin
            fault_latch <= 1'b1;
        end else if (flags.ramp_below_02 && flags.bias_above_94 && en_high) begin
            fault_latch <= 1'b0;
        end
    end

    // overvoltage: fixed threshold until the first ramp completion
    assign use_fixed = !ramp_seen || (flags.dyn_change && flags.diff_over_50);
    assign ov_trip = use_fixed ? flags.ov_over_fixed : flags.ov_over_dac;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ramp_seen <= 1'b0;
            ov_latch <= 1'b0;
        end else begin
            if (flags.ramp_above_392 && !fault_latch) begin
                ramp_seen <= 1'b1;
            end
            if (ov_trip) begin
                ov_latch <= 1'b1;
            end
        end
    end

    // open sense lines, checked only while test pulses are applied
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sense_latch <= 1'b0;
        end else if (pins.sense_test_pulse
                     && (flags.sense_pos_open || flags.sense_neg_open)) begin
            sense_latch <= 1'b1;
        end
    end

    // daisy chain: the returning pulse relaunches, so the ring period is
    // the phase count and a single phase runs at the timing clock rate
    assign chain_back = chain_sync && !chain_prev;
    assign chain_limit = learned ? phase_count : CHAIN_FIRST_LIMIT;
    assign launch = tick && (chain_state == CH_LAUNCH);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            chain_state <= CH_LAUNCH;
            chain_cnt <= 6'h00;
            phase_count <= 6'h00;
            learned <= 1'b0;
            missed_once <= 1'b0;
            chain_latch <= 1'b0;
            chain_phase_output <= 1'b0;
        end else begin
            unique case (chain_state)
                CH_LAUNCH: begin
                    if (tick) begin
                        chain_phase_output <= 1'b1;
                        chain_cnt <= 6'h00;
                        chain_state <= CH_WAIT;
                    end
                end
                CH_WAIT: begin
                    if (tick) begin
                        chain_phase_output <= 1'b0;
                    end
                    if (chain_back) begin
                        // end the pulse so a one-phase relaunch shows a fresh edge
                        chain_phase_output <= 1'b0;
                        if (!learned) begin
                            phase_count <= chain_cnt + 6'h01;
                        end
                        learned <= 1'b1;
                        missed_once <= 1'b0;
                        chain_state <= CH_LAUNCH;
                    end else if (tick) begin
                        if (chain_cnt + 6'h01 >= chain_limit) begin
                            missed_once <= 1'b1;
                            if (missed_once) begin
                                chain_latch <= 1'b1;
                                chain_state <= CH_DEAD;
                            end else begin
                                chain_state <= CH_LAUNCH;
                            end
                        end else begin
                            chain_cnt <= chain_cnt + 6'h01;
                        end
                    end
                end
                CH_DEAD: begin
                    chain_phase_output <= 1'b0;
                end
            endcase
        end
    end

    // pin drivers, all registered
    assign any_latch = fault_latch | ov_latch | sense_latch | chain_latch;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pins <= '0;
        end else begin
            pins.power_good <= !any_latch && !ov_trip && ramp_seen && flags.ramp_above_392
                               && flags.out_in_reg;
            pins.thermal_alarm_pull <= flags.hot_trip;
            pins.error_amp_clamp <= any_latch;
            pins.ramp_discharge <= any_latch;
            pins.ramp_charge <= !any_latch && en_high;
            pins.overvoltage_out <= ov_latch;
            pins.share_pullup <= ov_latch;
            pins.sense_test_pulse <= flags.sense_amp_low;
        end
    end

    // register bus write side
    assign do_write = aw_full && w_full && !bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b0;
            wready <= 1'b0;
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_addr <= 4'h0;
            w_byte0 <= 8'h00;
            w_strb0 <= 1'b0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            ctrl <= CTRL_RESET;
        end else begin
            if (awvalid && awready) begin
                aw_addr <= awaddr;
                aw_full <= 1'b1;
                awready <= 1'b0;
            end else if (!aw_full && !bvalid) begin
                awready <= 1'b1;
            end
            if (wvalid && wready) begin
                w_byte0 <= wdata[7:0];
                w_strb0 <= wstrb[0];
                w_full <= 1'b1;
                wready <= 1'b0;
            end else if (!w_full && !bvalid) begin
                wready <= 1'b1;
            end
            if (do_write) begin
                aw_full <= 1'b0;
                w_full <= 1'b0;
                bvalid <= 1'b1;
                if (aw_addr == ADDR_CTRL || aw_addr == ADDR_STATUS
                    || aw_addr == ADDR_PHASES) begin
                    bresp <= RESP_OKAY;
                end else begin
                    bresp <= RESP_SLVERR;
                end
                if (aw_addr == ADDR_CTRL && w_strb0) begin
                    ctrl <= w_byte0[1:0];
                end
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // register bus read side, status shows the latches
    always_comb begin
        read_word = 32'h0000_0000;
        read_ok = 1'b1;
        unique case (araddr)
            ADDR_CTRL:   read_word[1:0] = ctrl;
            ADDR_STATUS: read_word[7:0] = {loop_latch, code_sticky, pins.thermal_alarm_pull,
                                           pins.power_good, chain_latch, sense_latch,
                                           ov_latch, fault_latch};
            ADDR_PHASES: read_word[5:0] = phase_count;
            default:     read_ok = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= read_word;
            rresp <= read_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end else if (!rvalid) begin
            arready <= 1'b1;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_uvlo_sets_fault: assert property (
        flags.bias_below_86 |=> fault_latch ##1 pins.error_amp_clamp)
        else $error("undervoltage did not set fault latch");
    chk_code_qual_time: assert property (
        (code_bad && qual_cnt == CODE_QUAL_CNT - 8'h01) ##1 code_bad |-> fault_set ##1 fault_latch)
        else $error("qualified illegal code did not fault");
    chk_code_brief_ok: assert property (
        !code_bad |=> !code_fault_now)
        else $error("illegal code fault without persistence");
    chk_code_sticky_held: assert property (
        code_sticky |=> code_sticky && fault_latch)
        else $error("boot mode code fault released");
    chk_power_good_ramp_gate: assert property (
        pins.power_good |-> $past(flags.ramp_above_392 && flags.out_in_reg))
        else $error("power good without ramp or regulation");
    chk_power_good_latch_drop: assert property (
        any_latch |=> !pins.power_good)
        else $error("power good with a latch set");
    chk_loop_eight: assert property (
        flags.ea_high && launch && loop_cnt == OPEN_LOOP_LAST |=> loop_latch ##1 fault_latch)
        else $error("open loop not caught at eight cycles");
    chk_ov_outputs: assert property (
        $rose(ov_latch) |=> pins.overvoltage_out && pins.share_pullup && pins.error_amp_clamp)
        else $error("overvoltage outputs missing");
    chk_ov_sticky: assert property (
        ov_latch |=> ov_latch)
        else $error("overvoltage latch released");
    chk_fixed_powerup: assert property (
        !ramp_seen && flags.ov_over_fixed |=> ov_latch)
        else $error("power-up fixed threshold missed");
    chk_sense_open: assert property (
        pins.sense_test_pulse && flags.sense_neg_open |=> sense_latch ##1 pins.ramp_discharge)
        else $error("open sense line not latched");
    chk_chain_dead: assert property (
        chain_state == CH_DEAD |=> chain_latch && !pins.ramp_charge)
        else $error("open chain allows ramp charge");
    chk_thermal_pull: assert property (
        flags.hot_trip |=> pins.thermal_alarm_pull)
        else $error("thermal alarm not driven");
endmodule : regulator_fault_supervisor

// ### rtl/supervisor_pkg.sv
// constants, carriers and state codes for the regulator fault supervisor
// assumes a single 125 MHz clock and comparator flags arriving as plain levels
package supervisor_pkg;
    localparam int CLK_MHZ = 125;
    // illegal code qualification time, least time rounded up to whole cycles
    localparam int CODE_QUAL_NS = 1300;
    localparam int CODE_QUAL_CYC = (CODE_QUAL_NS * CLK_MHZ + 999) / 1000;
    localparam logic [7:0] CODE_QUAL_CNT = 8'(CODE_QUAL_CYC);
    // phase timing clock is one enable pulse every PHASE_DIV_LAST + 1 (16) system cycles
    localparam logic [3:0] PHASE_DIV_LAST = 4'hF;
    localparam logic [3:0] OPEN_LOOP_LAST = 4'h7;
    localparam logic [5:0] CHAIN_FIRST_LIMIT = 6'h20;

    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_PHASES = 4'h8;
    localparam int CTRL_FIVE_BIT = 0;
    localparam int CTRL_BOOT_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic bias_above_94;
        logic bias_below_86;
        logic ea_high;
        logic en_low_8;
        logic en_high_8;
        logic en_low_5;
        logic en_high_5;
        logic hot_trip;
        logic out_in_reg;
        logic ramp_above_392;
        logic ramp_below_02;
        logic ov_over_dac;
        logic ov_over_fixed;
        logic dyn_change;
        logic diff_over_50;
        logic sense_amp_low;
        logic sense_pos_open;
        logic sense_neg_open;
    } comp_flags_t;

    typedef struct packed {
        logic power_good;
        logic thermal_alarm_pull;
        logic error_amp_clamp;
        logic ramp_charge;
        logic ramp_discharge;
        logic overvoltage_out;
        logic share_pullup;
        logic sense_test_pulse;
    } supervisor_out_t;

    typedef enum logic [2:0] {
        CH_LAUNCH = 3'b001,
        CH_WAIT   = 3'b010,
        CH_DEAD   = 3'b100
    } chain_state_t;
endpackage : supervisor_pkg

// ### verification/phase_chain_model.sv
// phase chips on the daisy chain: pass the chain pulse back, act on the share line
// assumes the same clock as the supervisor and one timing tick of 16 cycles
module phase_chain_model (
    // clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // from the supervisor
    input  wire logic       chain_phase_output,
    input  wire logic       share_pullup,
    // chain set-up and breakage
    input  wire logic [3:0] phases,
    input  wire logic       cut,
    // to the supervisor; low_side_on goes to the bench
    output      logic       chain_phase_input,
    output      logic       low_side_on
);
    timeunit 1ns;
    timeprecision 1ps;
    int   cnt;
    logic last;
    // each extra phase holds the pulse one tick; a cut chain never answers
    always @(posedge aclk) begin
        last <= chain_phase_output;
        if (!aresetn)
            cnt <= 0;
        else if (chain_phase_output && !last && !cut)
            cnt <= (phases - 1) * 16 + 11;
        else if (cnt > 0)
            cnt <= cnt - 1;
        chain_phase_input <= (cnt > 0 && cnt < 5);
        low_side_on <= share_pullup;
    end
endmodule : phase_chain_model

// ### verification/tb.sv
// self-checking bench for the regulator fault supervisor
// assumes the phase chain model stands on the daisy chain
module tb;
    import supervisor_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
$display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
    logic            aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic            awready, wready, bvalid, arready, rvalid, cut, low_side_on, prev_out;
    logic            chain_phase_input, chain_phase_output, phase_timing_clock_out;
    logic [3:0]      awaddr, araddr, wstrb, phases;
    logic [31:0]     wdata, rdata, d;
    logic [1:0]      bresp, rresp, r;
    logic [7:0]      voltage_code, es;
    logic [7:0]      codes [4] = '{8'h00, 8'h01, 8'hFE, 8'hFF};
    comp_flags_t     flags;
    supervisor_out_t pins;
    int              n_fail = 0;
    int              samples_checked = 0;
    int              i, n_tick, n_edge;

    regulator_fault_supervisor dut (
        .aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .comp_flags(flags), .voltage_code(voltage_code),
        .chain_phase_input(chain_phase_input),
        .chain_phase_output(chain_phase_output),
        .phase_timing_clock_out(phase_timing_clock_out), .pins(pins)
    );
    phase_chain_model chain (
        .aclk(aclk), .aresetn(aresetn),
        .chain_phase_output(chain_phase_output), .share_pullup(pins.share_pullup),
        .phases(phases), .cut(cut),
        .chain_phase_input(chain_phase_input), .low_side_on(low_side_on)
    );

    initial begin
        aclk = 1'h0;
        forever #4 aclk = ~aclk;
    end

    task automatic give_verdict(input bit hung);
        if (hung)
            n_fail++;
        if (n_fail == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : give_verdict

    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask : cyc

    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        int k;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= v;
        awvalid <= 1'h1;
        wvalid  <= 1'h1;
        bready  <= 1'h1;
        for (k = 0; k < 50; k++) begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'h0;
            if (wready)
                wvalid <= 1'h0;
            if (bvalid)
                break;
        end
        if (k == 50)
            give_verdict(1);
        r = bresp;
        bready <= 1'h0;
    endtask : wr

    task automatic rd(input logic [3:0] a);
        int k;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'h1;
        rready  <= 1'h1;
        for (k = 0; k < 50; k++) begin
            @(posedge aclk);
            if (arready)
                arvalid <= 1'h0;
            if (rvalid)
                break;
        end
        if (k == 50)
            give_verdict(1);
        d = rdata;
        r = rresp;
        rready <= 1'h0;
    endtask : rd

    // status word against the bench model, only the bits in m
    task automatic st(input logic [7:0] m);
        rd(ADDR_STATUS);
        `CHK(d & {24'h0, m}, {24'h0, es & m})
    endtask : st

    // discharge the ramp to the bottom, then let it climb past the top again
    task automatic recover;
        flags.ramp_above_392 <= 1'h0;
        flags.ramp_below_02  <= 1'h1;
        cyc(20);
        flags.ramp_below_02  <= 1'h0;
        flags.ramp_above_392 <= 1'h1;
        cyc(20);
    endtask : recover

    // bias-rail power cycle; fin lets soft start finish
    task automatic pup(input logic [31:0] c, input bit fin);
        aresetn <= 1'h0;
        flags   <= '0;
        cyc(10);
        `CHK(pins, 8'h00)
        aresetn <= 1'h1;
        wr(ADDR_CTRL, c);
        es = 8'h01;
        st(8'h01);
        flags.bias_above_94 <= 1'h1;
        flags.en_high_8     <= !c[0];
        flags.en_high_5     <= c[0];
        flags.ramp_below_02 <= 1'h1;
        flags.out_in_reg    <= 1'h1;
        cyc(300);
        es = 8'h00;
        if (fin) begin
            flags.ramp_below_02  <= 1'h0;
            flags.ramp_above_392 <= 1'h1;
            cyc(20);
            es = 8'h10;
        end
    endtask : pup

    initial begin
        aresetn = 1'h0;
        awvalid = 1'h0;
        wvalid = 1'h0;
        bready = 1'h0;
        arvalid = 1'h0;
        rready = 1'h0;
        awaddr = 4'h0;
        araddr = 4'h0;
        wdata = 32'h0;
        wstrb = 4'hF;
        flags = '0;
        voltage_code = 8'h40;
        phases = 4'h3;
        cut = 1'h0;
        i = $urandom(32'h5596);
        pup(32'h0, 1'h1);
        st(8'hFF);
        rd(ADDR_PHASES);
        `CHK(d, 32'h3)
        rd(4'hC);
        `CHK(r, RESP_SLVERR)
        for (i = 0; i < 20; i++) begin
            voltage_code <= 8'h02 + 8'($urandom % 252);
            cyc(200);
            `CHK(pins.power_good, 1'h1)
        end
        voltage_code <= 8'hFF;
        cyc(150);
        voltage_code <= 8'h40;
        cyc(10);
        st(8'h11);
        foreach (codes[j]) begin
            voltage_code <= codes[j];
            cyc(175);
            `CHK(pins.error_amp_clamp, 1'h1)
            `CHK(pins.power_good, 1'h0)
            voltage_code <= 8'h40;
            recover();
            st(8'h11);
        end
        flags.en_low_5 <= 1'h1;
        cyc(10);
        st(8'h11);
        flags.en_low_8  <= 1'h1;
        flags.en_high_8 <= 1'h0;
        cyc(10);
        es = 8'h01;
        st(8'h11);
        flags.en_low_5  <= 1'h0;
        flags.en_low_8  <= 1'h0;
        flags.en_high_8 <= 1'h1;
        recover();
        es = 8'h10;
        st(8'h11);
        flags.bias_below_86 <= 1'h1;
        cyc(10);
        `CHK(pins.error_amp_clamp, 1'h1)
        `CHK(pins.power_good, 1'h0)
        flags.bias_below_86 <= 1'h0;
        recover();
        st(8'h11);
        flags.hot_trip <= 1'h1;
        cyc(6);
        `CHK(pins.thermal_alarm_pull, 1'h1)
        es = 8'h30;
        st(8'h30);
        flags.hot_trip <= 1'h0;
        cyc(6);
        `CHK(pins.thermal_alarm_pull, 1'h0)
        es = 8'h10;
        flags.ea_high <= 1'h1;
        cyc(100);
        flags.ea_high <= 1'h0;
        cyc(10);
        st(8'h91);
        flags.ea_high <= 1'h1;
        cyc(500);
        flags.ea_high <= 1'h0;
        recover();
        es = 8'h81;
        st(8'h91);
        pup(32'h0, 1'h1);
        flags.dyn_change   <= 1'h1;
        flags.diff_over_50 <= 1'h1;
        flags.ov_over_dac  <= 1'h1;
        cyc(10);
        st(8'h12);
        flags.diff_over_50 <= 1'h0;
        cyc(10);
        `CHK(pins.overvoltage_out, 1'h1)
        `CHK(pins.share_pullup, 1'h1)
        `CHK(pins.power_good, 1'h0)
        `CHK(low_side_on, 1'h1)
        flags.ov_over_dac <= 1'h0;
        flags.dyn_change  <= 1'h0;
        recover();
        es = 8'h02;
        st(8'h12);
        pup(32'h0, 1'h1);
        flags.sense_amp_low <= 1'h1;
        cyc(6);
        `CHK(pins.sense_test_pulse, 1'h1)
        flags.sense_neg_open <= 1'h1;
        cyc(6);
        `CHK(pins.error_amp_clamp, 1'h1)
        `CHK(pins.ramp_discharge, 1'h1)
        flags.sense_amp_low  <= 1'h0;
        flags.sense_neg_open <= 1'h0;
        recover();
        es = 8'h04;
        st(8'h16);
        pup(32'h1, 1'h1);
        voltage_code <= 8'hFE;
        cyc(180);
        st(8'h11);
        voltage_code <= 8'h1F;
        cyc(180);
        es = 8'h01;
        st(8'h11);
        voltage_code <= 8'h40;
        recover();
        es = 8'h10;
        st(8'h11);
        pup(32'h2, 1'h1);
        voltage_code <= 8'h00;
        cyc(180);
        voltage_code <= 8'h40;
        recover();
        es = 8'h41;
        st(8'hD1);
        pup(32'h0, 1'h0);
        flags.ov_over_dac <= 1'h1;
        cyc(20);
        st(8'h02);
        flags.ramp_below_02  <= 1'h0;
        flags.ramp_above_392 <= 1'h1;
        cyc(10);
        es = 8'h02;
        st(8'h12);
        pup(32'h0, 1'h0);
        flags.ov_over_fixed <= 1'h1;
        cyc(10);
        es = 8'h02;
        st(8'h02);
        phases <= 4'h1;
        pup(32'h0, 1'h1);
        rd(ADDR_PHASES);
        `CHK(d, 32'h1)
        prev_out = chain_phase_output;
        n_tick = 0;
        n_edge = 0;
        repeat (160) begin
            @(posedge aclk);
            if (phase_timing_clock_out)
                n_tick++;
            if (chain_phase_output && !prev_out)
                n_edge++;
            prev_out = chain_phase_output;
        end
        `CHK(n_tick, 10)
        `CHK(n_edge, 10)
        cut <= 1'h1;
        cyc(100);
        es = 8'h08;
        st(8'h18);
        `CHK(pins.ramp_charge, 1'h0)
        pup(32'h0, 1'h0);
        cyc(1100);
        es = 8'h08;
        st(8'h18);
        give_verdict(1'h0);
    end
endmodule : tb
